//--- design/ppc_pkg.sv
// shared constants and types for the parallel port configuration bank
package ppc_pkg;

    // =========================================================
    // register offsets
    localparam logic [7:0] PPC_ADDR_MODE  = 8'hf0; // port mode / threshold / irq type
    localparam logic [7:0] PPC_ADDR_MODE2 = 8'hf1; // timeout clear select
    localparam logic [7:0] PPC_ADDR_MAP   = 8'hf8; // one-hot mode alias

    // =========================================================
    // reset values
    localparam logic [7:0] PPC_RST_MODE   = 8'h3c; // printer mode, threshold 0111b
    localparam logic [7:0] PPC_RST_MODE2  = 8'h00;
    localparam logic [7:0] PPC_RST_MAP    = 8'h08; // printer one-hot code

    // =========================================================
    // field positions
    localparam int PPC_MODE_LSB = 0;  // mode field of the mode register
    localparam int PPC_MODE_MSB = 2;
    localparam int PPC_THR_LSB  = 3;  // fifo threshold field
    localparam int PPC_THR_MSB  = 6;
    localparam int PPC_ITYPE    = 7;  // interrupt type bit
    localparam int PPC_TSEL     = 4;  // timeout clear select bit
    localparam int PPC_MAP_LSB  = 0;  // one-hot mode field of the alias
    localparam int PPC_MAP_MSB  = 3;
    localparam int PPC_ALIAS_LSB = 1; // alias bits linked to the mode field
    localparam int PPC_ALIAS_MSB = 3;

    // =========================================================
    // three-bit port mode codes
    localparam logic [2:0] PPC_MODE_PRN       = 3'h4; // printer
    localparam logic [2:0] PPC_MODE_SPP       = 3'h0; // standard bidirectional
    localparam logic [2:0] PPC_MODE_EPP19     = 3'h1; // epp-1.9 with spp
    localparam logic [2:0] PPC_MODE_EPP17     = 3'h5; // epp-1.7 with spp
    localparam logic [2:0] PPC_MODE_ECP       = 3'h2; // ecp
    localparam logic [2:0] PPC_MODE_ECP_EPP19 = 3'h3; // ecp with epp-1.9
    localparam logic [2:0] PPC_MODE_ECP_EPP17 = 3'h7; // ecp with epp-1.7

    // =========================================================
    // one-hot alias codes
    localparam logic [3:0] PPC_MAP_SPP   = 4'h1;
    localparam logic [3:0] PPC_MAP_EPP19 = 4'h2;
    localparam logic [3:0] PPC_MAP_ECP   = 4'h4;
    localparam logic [3:0] PPC_MAP_PRN   = 4'h8;

    // =========================================================
    // timing
    localparam int PPC_CLK_PERIOD_NS = 40; // 25 mhz core clock
    localparam int PPC_IRQ_PULSE_NS  = 80; // least width of the low interrupt pulse
    localparam int PPC_IRQ_PULSE_CYC =
        (PPC_IRQ_PULSE_NS + PPC_CLK_PERIOD_NS - 1) / PPC_CLK_PERIOD_NS;
    localparam logic [3:0] PPC_IRQ_PULSE_LAST = 4'(PPC_IRQ_PULSE_CYC - 1);

    // =========================================================
    // types
    typedef enum logic [1:0] {PPC_IRQ_FOLLOW, PPC_IRQ_PULSE, PPC_IRQ_LEVEL} ppc_irq_style_t;
    typedef enum logic {PPC_PULSE_IDLE, PPC_PULSE_DRIVE} ppc_pulse_state_t;

endpackage : ppc_pkg

//--- design/ppc_tmo_flag.sv
// enhanced-protocol timeout flag with selectable clear
module ppc_tmo_flag
    import ppc_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_timeout_event,  // datapath saw a timeout
    input  wire logic i_clear_sel,      // 0 write-one clear, 1 read clear
    input  wire logic i_status_wr,      // status register write
    input  wire logic i_status_wr_one,  // flag bit written as one
    input  wire logic i_status_rd,      // status read in progress, level
    output logic      o_flag            // enhanced_timeout_flag
);

    logic flag_reg;    // the flag
    logic flag_next;
    logic rd_reg;      // previous read level
    logic rd_next;
    logic clr;         // clear request this cycle

    // =========================================================
    // next state: set wins over clear
    always_comb
    begin
        rd_next = i_status_rd;
        if (i_clear_sel)
            clr = rd_reg && !i_status_rd;           // trailing edge of read
        else
            clr = i_status_wr && i_status_wr_one;   // write of one
        flag_next = i_timeout_event || (flag_reg && !clr);
    end

    // registers
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            flag_reg <= 1'b0;
            rd_reg   <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
            rd_reg   <= rd_next;
        end
    end

    assign o_flag = flag_reg;

endmodule : ppc_tmo_flag

//--- design/ppc_irq_gen.sv
// port interrupt shaping: follow acknowledge, low pulse, or level
module ppc_irq_gen
    import ppc_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [2:0] i_port_mode,        // selected port mode
    input  wire logic       i_irq_type,         // interrupt type bit
    input  wire logic       i_acknowledge_in_n, // pin, asynchronous
    input  wire logic       i_ecp_irq_level,    // ecp request level
    input  wire logic       i_ecp_sub_compat,   // ecp running printer/spp/epp
    output logic            o_irq,              // interrupt level out
    output logic            o_irq_oe            // high while driving
);

    logic             ack_s1_reg, ack_s2_reg, ack_d_reg; // sync chain and edge
    logic             lvl_d_reg;                          // previous ecp level
    ppc_irq_style_t   style;
    ppc_pulse_state_t st_reg, st_next;
    logic [3:0]       cnt_reg, cnt_next;
    logic             irq_next, oe_next, trig, basic, epp;

    // =========================================================
    // choose the drive style from mode and type
    always_comb
    begin
        basic = (i_port_mode == PPC_MODE_PRN) || (i_port_mode == PPC_MODE_SPP);
        epp   = (i_port_mode == PPC_MODE_EPP19) || (i_port_mode == PPC_MODE_EPP17);
        if (basic)
            style = PPC_IRQ_FOLLOW;              // type bit ignored
        else if (i_irq_type)
            style = PPC_IRQ_PULSE;
        else if (epp || i_ecp_sub_compat)
            style = PPC_IRQ_FOLLOW;
        else
            style = PPC_IRQ_LEVEL;
        trig = (ack_d_reg && !ack_s2_reg) || (i_ecp_irq_level && !lvl_d_reg);
    end

    // =========================================================
    // pulse machine and output values
    always_comb
    begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        case (st_reg)
            PPC_PULSE_IDLE:
            begin
                cnt_next = 4'h0;
                if (style == PPC_IRQ_PULSE && trig)
                    st_next = PPC_PULSE_DRIVE;
            end
            default:
            begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == PPC_IRQ_PULSE_LAST)
                    st_next = PPC_PULSE_IDLE;    // release to high-z
            end
        endcase
        case (style)
            PPC_IRQ_FOLLOW:
            begin
                irq_next = ack_s2_reg;
                oe_next  = 1'b1;
            end
            PPC_IRQ_LEVEL:
            begin
                irq_next = i_ecp_irq_level;
                oe_next  = 1'b1;
            end
            default:
            begin
                irq_next = 1'b0;
                oe_next  = (st_next == PPC_PULSE_DRIVE);
            end
        endcase
    end

    // registers
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            ack_s1_reg <= 1'b1;
            ack_s2_reg <= 1'b1;
            ack_d_reg  <= 1'b1;
            lvl_d_reg  <= 1'b0;
            st_reg     <= PPC_PULSE_IDLE;
            cnt_reg    <= 4'h0;
            o_irq      <= 1'b1;
            o_irq_oe   <= 1'b0;
        end
        else
        begin
            ack_s1_reg <= i_acknowledge_in_n;
            ack_s2_reg <= ack_s1_reg;
            ack_d_reg  <= ack_s2_reg;
            lvl_d_reg  <= i_ecp_irq_level;
            st_reg     <= st_next;
            cnt_reg    <= cnt_next;
            o_irq      <= irq_next;
            o_irq_oe   <= oe_next;
        end
    end

    a_pulse_drives_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (style == PPC_IRQ_PULSE && st_reg == PPC_PULSE_DRIVE) |-> (o_irq_oe && !o_irq))
        else $error("pulse state not driving low");

endmodule : ppc_irq_gen

//--- design/ppc_config_regs.sv
// parallel port configuration register bank, top level
module ppc_config_regs
    import ppc_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr_stb,
    input  wire logic       i_rd_stb,
    output logic      [7:0] o_rd_data,
    input  wire logic       i_acknowledge_in_n,
    input  wire logic       i_ecp_irq_level,
    input  wire logic       i_ecp_sub_compat,
    input  wire logic       i_timeout_event,
    input  wire logic       i_status_wr,
    input  wire logic       i_status_wr_one,
    input  wire logic       i_status_rd,
    output logic      [2:0] o_port_mode,
    output logic      [3:0] o_fifo_threshold,
    output logic            o_irq,
    output logic            o_irq_oe,
    output logic            o_enhanced_timeout_flag
);

    // =========================================================
    // register state
    logic [2:0] mode_reg;    // selected port mode
    logic [2:0] mode_next;
    logic [3:0] thr_reg;     // ecp fifo threshold
    logic [3:0] thr_next;
    logic       itype_reg;   // interrupt type
    logic       itype_next;
    logic       tsel_reg;    // timeout clear select
    logic       tsel_next;
    logic [3:0] map_reg;     // one-hot alias field
    logic [3:0] map_next;
    logic [7:0] rd_reg;      // read data, one cycle after strobe
    logic [7:0] rd_next;

    // decoded helpers
    logic       wr_mode;     // write hits mode register
    logic       wr_mode2;    // write hits second mode register
    logic       wr_map;      // write hits alias register
    logic [2:0] wr_code;     // mode code from write data
    logic [3:0] wr_hot;      // alias code from write data
    logic       code_mapped; // mode code has a one-hot alias
    logic       hot_valid;   // alias code is a defined one

    // =========================================================
    // address decode
    always_comb
    begin
        wr_mode  = 1'b0;
        wr_mode2 = 1'b0;
        wr_map   = 1'b0;
        // strobe qualifies every hit
        if (i_wr_stb && i_addr == PPC_ADDR_MODE)
            wr_mode = 1'b1;
        else if (i_wr_stb && i_addr == PPC_ADDR_MODE2)
            wr_mode2 = 1'b1;
        else if (i_wr_stb && i_addr == PPC_ADDR_MAP)
            wr_map = 1'b1;
    end

    // =========================================================
    // code classification
    always_comb
    begin
        // fields as written
        wr_code = i_wr_data[PPC_MODE_MSB:PPC_MODE_LSB];
        wr_hot  = i_wr_data[PPC_MAP_MSB:PPC_MAP_LSB];
        // only these four modes have a one-hot alias
        code_mapped = (wr_code == PPC_MODE_SPP) || (wr_code == PPC_MODE_EPP19)
                   || (wr_code == PPC_MODE_ECP) || (wr_code == PPC_MODE_PRN);
        // other alias codes are reserved
        hot_valid = (wr_hot == PPC_MAP_SPP) || (wr_hot == PPC_MAP_EPP19)
                 || (wr_hot == PPC_MAP_ECP) || (wr_hot == PPC_MAP_PRN);
    end

    // =========================================================
    // next register values
    always_comb
    begin
        // hold by default
        mode_next  = mode_reg;
        thr_next   = thr_reg;
        itype_next = itype_reg;
        tsel_next  = tsel_reg;
        map_next   = map_reg;
        if (wr_mode)
        begin
            // every code selects its mode
            mode_next  = wr_code;
            thr_next   = i_wr_data[PPC_THR_MSB:PPC_THR_LSB];
            itype_next = i_wr_data[PPC_ITYPE];
            // alias only tracks modes it can express
            if (code_mapped)
                map_next = {wr_code, (wr_code == PPC_MODE_SPP)};
        end
        else if (wr_mode2)
        begin
            // reserved bits are not stored
            tsel_next = i_wr_data[PPC_TSEL];
        end
        else if (wr_map)
        begin
            // reserved alias codes are ignored whole
            if (hot_valid)
            begin
                map_next  = wr_hot;
                mode_next = i_wr_data[PPC_ALIAS_MSB:PPC_ALIAS_LSB];
            end
        end
    end

    // =========================================================
    // read mux; unmapped offsets read zero
    always_comb
    begin
        rd_next = 8'h00;
        // one offset per strobe
        if (i_rd_stb && i_addr == PPC_ADDR_MODE)
            rd_next = {itype_reg, thr_reg, mode_reg};
        else if (i_rd_stb && i_addr == PPC_ADDR_MODE2)
            rd_next[PPC_TSEL] = tsel_reg;
        else if (i_rd_stb && i_addr == PPC_ADDR_MAP)
            rd_next[PPC_MAP_MSB:PPC_MAP_LSB] = map_reg;
    end

    // =========================================================
    // register update with synchronous reset
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            // all three reset kinds arrive on this one input
            mode_reg  <= PPC_RST_MODE[PPC_MODE_MSB:PPC_MODE_LSB];
            thr_reg   <= PPC_RST_MODE[PPC_THR_MSB:PPC_THR_LSB];
            itype_reg <= PPC_RST_MODE[PPC_ITYPE];
            tsel_reg  <= PPC_RST_MODE2[PPC_TSEL];
            map_reg   <= PPC_RST_MAP[PPC_MAP_MSB:PPC_MAP_LSB];
            rd_reg    <= 8'h00;
        end
        else
        begin
            // take next values
            mode_reg  <= mode_next;
            thr_reg   <= thr_next;
            itype_reg <= itype_next;
            tsel_reg  <= tsel_next;
            map_reg   <= map_next;
            rd_reg    <= rd_next;
        end
    end

    // =========================================================
    // outputs from flip-flops
    assign o_rd_data        = rd_reg;
    assign o_port_mode      = mode_reg;
    assign o_fifo_threshold = thr_reg;

    // =========================================================
    // interrupt shaping
    // style from mode and type bit
    ppc_irq_gen u_irq
    (
        .i_core_clk         (i_core_clk),
        .i_rst              (i_rst),
        .i_port_mode        (mode_reg),
        .i_irq_type         (itype_reg),
        .i_acknowledge_in_n (i_acknowledge_in_n),
        .i_ecp_irq_level    (i_ecp_irq_level),
        .i_ecp_sub_compat   (i_ecp_sub_compat),
        .o_irq              (o_irq),
        .o_irq_oe           (o_irq_oe)
    );

    // =========================================================
    // timeout flag
    // clear style from select bit
    ppc_tmo_flag u_tmo
    (
        .i_core_clk      (i_core_clk),
        .i_rst           (i_rst),
        .i_timeout_event (i_timeout_event),
        .i_clear_sel     (tsel_reg),
        .i_status_wr     (i_status_wr),
        .i_status_wr_one (i_status_wr_one),
        .i_status_rd     (i_status_rd),
        .o_flag          (o_enhanced_timeout_flag)
    );

    // =========================================================
    // checks
    // reset image
    a_reset_loads_defaults: assert property (@(posedge i_core_clk)
        i_rst |=> (mode_reg == PPC_MODE_PRN && thr_reg == 4'h7 && !itype_reg
                   && !tsel_reg && map_reg == PPC_MAP_PRN))
        else $error("reset values wrong");

    // mode write lands
    a_mode_write_takes: assert property (@(posedge i_core_clk) disable iff (i_rst)
        wr_mode |=> (o_port_mode == $past(i_wr_data[2:0])))
        else $error("mode write not taken");

    // unmapped code keeps alias
    a_alias_kept_unmapped: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_mode && !code_mapped) |=> $stable(map_reg))
        else $error("alias changed on unmapped code");

    // mapped code moves alias
    a_alias_tracks_mode: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_mode && code_mapped) |=> (map_reg[3:1] == o_port_mode
                                      && map_reg[0] == (o_port_mode == PPC_MODE_SPP)))
        else $error("alias not tracking mode");

    // threshold lands
    a_threshold_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
        wr_mode |=> (o_fifo_threshold == $past(i_wr_data[6:3])))
        else $error("threshold not stored");

    // alias write moves mode
    a_alias_sets_mode: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_map && hot_valid) |=> (map_reg == $past(i_wr_data[3:0])
                                   && o_port_mode == $past(i_wr_data[3:1])))
        else $error("alias write did not select mode");

    // mapped mode agrees
    a_readback_consistent: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (mode_reg == PPC_MODE_SPP || mode_reg == PPC_MODE_EPP19
         || mode_reg == PPC_MODE_ECP || mode_reg == PPC_MODE_PRN)
        |-> (map_reg[3:1] == mode_reg && map_reg[0] == (mode_reg == PPC_MODE_SPP)))
        else $error("mode and alias disagree");

    // mode read image
    a_mode_read_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_rd_stb && i_addr == PPC_ADDR_MODE)
        |=> (o_rd_data == {$past(itype_reg), $past(thr_reg), $past(mode_reg)}))
        else $error("mode read data wrong");

    // reserved bits read zero
    a_mode2_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_rd_stb && i_addr == PPC_ADDR_MODE2) |=> ((o_rd_data & 8'hef) == 8'h00))
        else $error("reserved bits not zero");

    // event sets, set wins
    a_timeout_set_wins: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_timeout_event |=> o_enhanced_timeout_flag)
        else $error("timeout event lost");

    // write-one clear
    a_timeout_write_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!tsel_reg && i_status_wr && i_status_wr_one && !i_timeout_event)
        |=> !o_enhanced_timeout_flag)
        else $error("write-one clear failed");

    // basic modes keep driving
    a_basic_no_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ((mode_reg == PPC_MODE_PRN || mode_reg == PPC_MODE_SPP) [*2]) |=> o_irq_oe)
        else $error("irq released in basic mode");

    // ecp level passes through
    a_ecp_level_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ((mode_reg == PPC_MODE_ECP && !itype_reg && !i_ecp_sub_compat) [*2])
        |=> (o_irq_oe && o_irq == $past(i_ecp_irq_level)))
        else $error("ecp level interrupt wrong");

    // bad alias code
    a_alias_bad_ignored: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_map && !hot_valid)
        |=> ($stable(map_reg) && $stable(mode_reg)))
        else $error("reserved alias taken");

    // select bit stored
    a_select_stored: assert property (@(posedge i_core_clk) disable iff (i_rst)
        wr_mode2
        |=> (tsel_reg == $past(i_wr_data[PPC_TSEL])))
        else $error("select not stored");

    // read trailing edge
    a_timeout_read_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (tsel_reg && $past(i_status_rd) && !i_status_rd && !i_timeout_event)
        |=> !o_enhanced_timeout_flag)
        else $error("read clear failed");

    // alias high bits
    a_map_high_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_rd_stb && i_addr == PPC_ADDR_MAP)
        |=> (o_rd_data[7:4] == 4'h0))
        else $error("alias high bits set");

endmodule : ppc_config_regs

//--- testbench/ppc_config_regs_bench.sv
// self-checking bench for the parallel port configuration bank
module ppc_config_regs_bench
    import ppc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================
    // signals
    typedef struct {
        logic [7:0] wa; // write address
        logic [7:0] wd; // write data
        logic [7:0] ra; // read-back address
        logic [7:0] rv; // expected read-back
        logic [2:0] pm; // expected port mode
    } ppc_row_t;

    logic       i_core_clk;         // 25 mhz core clock
    logic       i_rst;              // synchronous reset
    logic [7:0] i_addr;             // register offset
    logic [7:0] i_wr_data;          // write data
    logic       i_wr_stb;           // write strobe
    logic       i_rd_stb;           // read strobe
    logic [7:0] o_rd_data;          // read data
    logic       i_acknowledge_in_n; // acknowledge pin
    logic       i_ecp_irq_level;    // ecp request level
    logic       i_ecp_sub_compat;   // ecp sub-mode
    logic       i_timeout_event;    // timeout from datapath
    logic       i_status_wr;        // status write pulse
    logic       i_status_wr_one;    // flag written as one
    logic       i_status_rd;        // status read level
    logic [2:0] o_port_mode;        // selected mode
    logic [3:0] o_fifo_threshold;   // threshold field
    logic       o_irq;              // interrupt value
    logic       o_irq_oe;           // interrupt drive enable
    logic       o_enhanced_timeout_flag;
    int         mismatches = 0;     // failed comparisons
    int         n_checks   = 0;     // all comparisons
    int         cycles     = 0;     // timeout counter

    // register cases, a reserved alias code and an unmapped offset among them: write, read back, expected mode
    ppc_row_t rows [16] = '{
        '{8'hf0, 8'h02, 8'hf8, 8'h04, 3'h2}, '{8'hf0, 8'h00, 8'hf8, 8'h01, 3'h0},
        '{8'hf0, 8'h01, 8'hf8, 8'h02, 3'h1}, '{8'hf0, 8'h04, 8'hf8, 8'h08, 3'h4},
        '{8'hf0, 8'h05, 8'hf8, 8'h08, 3'h5}, '{8'hf0, 8'h03, 8'hf8, 8'h08, 3'h3},
        '{8'hf0, 8'h07, 8'hf8, 8'h08, 3'h7}, '{8'hf8, 8'h02, 8'hf0, 8'h01, 3'h1},
        '{8'hf8, 8'h03, 8'hf0, 8'h01, 3'h1}, '{8'hf8, 8'h04, 8'hf0, 8'h02, 3'h2},
        '{8'hf8, 8'h01, 8'hf0, 8'h00, 3'h0}, '{8'hf8, 8'h08, 8'hf0, 8'h04, 3'h4},
        '{8'hf0, 8'hbd, 8'hf0, 8'hbd, 3'h5}, '{8'hf0, 8'hbd, 8'hf8, 8'h08, 3'h5},
        '{8'hf1, 8'h10, 8'hf1, 8'h10, 3'h5}, '{8'h55, 8'hff, 8'h55, 8'h00, 3'h5}
    };

    // =========================================================
    // design under test
    ppc_config_regs dut_u (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
        .i_acknowledge_in_n(i_acknowledge_in_n), .i_ecp_irq_level(i_ecp_irq_level),
        .i_ecp_sub_compat(i_ecp_sub_compat), .i_timeout_event(i_timeout_event),
        .i_status_wr(i_status_wr), .i_status_wr_one(i_status_wr_one),
        .i_status_rd(i_status_rd), .o_port_mode(o_port_mode),
        .o_fifo_threshold(o_fifo_threshold), .o_irq(o_irq), .o_irq_oe(o_irq_oe),
        .o_enhanced_timeout_flag(o_enhanced_timeout_flag)
    );

    // =========================================================
    // clock and hang guard
    initial
    begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            stop_test();
        end
    end

    // =========================================================
    // tasks
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
        n_checks++;
        if (got !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, e, got);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr    <= a;
        i_wr_data <= d;
        i_wr_stb  <= 1'b1;
        @(posedge i_core_clk);
        i_wr_stb  <= 1'b0;
    endtask : wr

    // one-cycle read; data stands one cycle then drops to zero
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge i_core_clk);
        i_addr   <= a;
        i_rd_stb <= 1'b1;
        @(posedge i_core_clk);
        i_rd_stb <= 1'b0;
        @(negedge i_core_clk);
        chk(what, e, o_rd_data);
        @(negedge i_core_clk);
        chk("read idle", 8'h00, o_rd_data);
    endtask : rd

    // status side inputs {event, wr, wr_one, rd} held n cycles
    task automatic side(input logic [3:0] v, input int n);
        @(posedge i_core_clk);
        {i_timeout_event, i_status_wr, i_status_wr_one, i_status_rd} <= v;
        repeat (n) @(posedge i_core_clk);
        {i_timeout_event, i_status_wr, i_status_wr_one, i_status_rd} <= 4'h0;
        repeat (2) @(negedge i_core_clk);
    endtask : side

    // reset contents of all three registers
    task automatic chk_reset();
        rd(PPC_ADDR_MODE, 8'h3c, "mode reg");
        rd(PPC_ADDR_MODE2, 8'h00, "mode2 reg");
        rd(PPC_ADDR_MAP, 8'h08, "map reg");
        chk("port mode", 8'h04, o_port_mode);
        chk("threshold", 8'h07, o_fifo_threshold);
    endtask : chk_reset

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // =========================================================
    // main sequence
    initial
    begin
        i_rst = 1'b1; i_addr = 8'h00; i_wr_data = 8'h00; i_wr_stb = 1'b0; i_rd_stb = 1'b0;
        i_acknowledge_in_n = 1'b1; i_ecp_irq_level = 1'b0; i_ecp_sub_compat = 1'b0;
        {i_timeout_event, i_status_wr, i_status_wr_one, i_status_rd} = 4'h0;
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        chk_reset();
        // table of register cases
        foreach (rows[k])
        begin
            wr(rows[k].wa, rows[k].wd);
            rd(rows[k].ra, rows[k].rv, "readback");
            chk("mode out", 8'(rows[k].pm), o_port_mode);
        end
        // timeout flag, read-trailing-edge clear selected
        side(4'h8, 1);
        chk("flag set", 8'h01, o_enhanced_timeout_flag);
        side(4'h6, 1);
        chk("flag kept", 8'h01, o_enhanced_timeout_flag);
        side(4'h1, 2);
        chk("flag rd clr", 8'h00, o_enhanced_timeout_flag);
        // write-one clear selected
        wr(PPC_ADDR_MODE2, 8'h00);
        side(4'h8, 1);
        side(4'h1, 2);
        chk("flag kept", 8'h01, o_enhanced_timeout_flag);
        side(4'h6, 1);
        chk("flag wr clr", 8'h00, o_enhanced_timeout_flag);
        // pulse style: epp-1.9, type one
        wr(PPC_ADDR_MODE, 8'h81);
        repeat (5) @(posedge i_core_clk);
        chk("thr write", 8'h00, 8'(o_fifo_threshold));
        i_acknowledge_in_n <= 1'b0;
        for (int w = 0; w < 10 && o_irq_oe !== 1'b1; w++) @(negedge i_core_clk);
        chk("pulse irq", 8'h00, o_irq);
        @(negedge i_core_clk);
        chk("pulse 2nd", 8'h01, {o_irq_oe, o_irq} == 2'b10);
        @(negedge i_core_clk);
        chk("pulse off", 8'h00, o_irq_oe);
        // type bit ignored in spp: follows acknowledge, driven
        wr(PPC_ADDR_MODE, 8'h80);
        repeat (6) @(negedge i_core_clk);
        chk("spp irq", 8'h02, {o_irq_oe, o_irq});
        // follow style: epp-1.9, type zero
        wr(PPC_ADDR_MODE, 8'h01);
        @(posedge i_core_clk);
        i_acknowledge_in_n <= 1'b1;
        repeat (6) @(negedge i_core_clk);
        chk("follow hi", 8'h03, {o_irq_oe, o_irq});
        @(posedge i_core_clk);
        i_acknowledge_in_n <= 1'b0;
        repeat (6) @(negedge i_core_clk);
        chk("follow lo", 8'h02, {o_irq_oe, o_irq});
        // level style: ecp
        wr(PPC_ADDR_MODE, 8'h02);
        @(posedge i_core_clk);
        i_ecp_irq_level <= 1'b1;
        repeat (8) @(negedge i_core_clk);
        chk("level hi", 8'h03, {o_irq_oe, o_irq});
        @(posedge i_core_clk);
        i_ecp_irq_level <= 1'b0;
        repeat (3) @(negedge i_core_clk);
        chk("level lo", 8'h00, o_irq);
        // ecp in a compatible sub-mode follows acknowledge
        @(posedge i_core_clk);
        i_ecp_sub_compat   <= 1'b1;
        i_acknowledge_in_n <= 1'b1;
        repeat (6) @(negedge i_core_clk);
        chk("ecp follow", 8'h03, {o_irq_oe, o_irq});
        // second reset in mid-run, flag raised first
        side(4'h8, 1);
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (3) @(negedge i_core_clk);
        chk("rst drive", 8'h01, {o_irq_oe, o_irq});
        chk("rst flag", 8'h00, o_enhanced_timeout_flag);
        @(posedge i_core_clk);
        i_rst <= 1'b0;
        chk_reset();
        stop_test();
    end

endmodule : ppc_config_regs_bench
